/* design/mmd_pkg.sv */
package mmd_pkg;
  // clock and machine cycle
  localparam int unsigned CLK_HZ            = 40000000;
  localparam int unsigned CLKS_PER_MCYCLE   = 2;
  localparam int unsigned CORE_CLK_MHZ      = 60;
  localparam int unsigned MIPS_MAX          = CORE_CLK_MHZ / CLKS_PER_MCYCLE;
  // internal data memory
  localparam logic [10:0] IMEM_BASE         = 11'h000;
  localparam int unsigned IMEM_BYTES        = 1152;
  // code space
  localparam logic [15:0] ROM_BASE          = 16'h0000;
  localparam logic [15:0] ROM_LAST          = 16'h1fff;
  localparam logic [15:0] FIXRAM_BASE       = 16'h2000;
  localparam logic [15:0] FIXRAM_LAST       = 16'h3fff;
  localparam logic [15:0] CFGRAM_LAST_P00   = 16'h9fff;
  localparam logic [15:0] CFGRAM_LAST_P01   = 16'h5fff;
  localparam logic [15:0] CFGRAM_LAST_P10   = 16'h3fff;
  // external data space
  localparam logic [15:0] EPBUF_BASE        = 16'he000;
  localparam logic [15:0] EPBUF_LAST        = 16'hefff;
  localparam logic [15:0] MMR_BASE          = 16'hf000;
  localparam logic [15:0] MMR_LAST          = 16'hf0f9;
  // shared ram: code window of 32k followed by fixed fifo 8k (40k total)
  localparam int unsigned CODE_RAM_BYTES    = 32768;
  localparam int unsigned FIFO_FIX_BYTES    = 8192;
  localparam logic [1:0]  PART_RESET        = 2'h0;
  typedef enum logic [1:0] {
    MMD_PART_32K = 2'h0,
    MMD_PART_16K = 2'h1,
    MMD_PART_8K  = 2'h2,
    MMD_PART_RSV = 2'h3
  } mmd_part_t;
  typedef enum logic [2:0] {
    MMD_TGT_NONE, MMD_TGT_ROM, MMD_TGT_CRAM, MMD_TGT_EPBUF, MMD_TGT_MMR
  } mmd_tgt_t;
endpackage

/* design/mmd_decoder.sv */
// Overview of operation
// - every machine cycle takes exactly two clocks, for all instructions
// - internal data memory holds 1152 bytes starting at address 0x00
// - code 0000-1FFF decodes to the 8K boot rom
// - code 2000-3FFF always decodes to 8K firmware ram
// - a further 8K ram is always sector fifo, reached only by the ata side
// - external data E000-EFFF decodes to the 4K endpoint buffer ram
// - external data F000-F0F9 decodes to the register window
// - ram 4000-9FFF goes to code or fifo by the partition field
// - partition resets to 00: code ram 2000-9FFF, 8K fifo
// - partition 01: code ram 2000-5FFF, 24K fifo
// - partition 10: code ram 2000-3FFF, 32K fifo
// - core clock nominally 60 MHz, up to 30 million instructions per second
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder #(
  parameter int unsigned RAM_AW  = 16,
  parameter int unsigned ROM_AW  = 13,
  parameter int unsigned IDAT_AW = 11
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // partition control from firmware
  input  wire logic              ram_partition_wr,
  input  wire logic [1:0]        ram_partition_wdata,
  output logic      [1:0]        ram_partition_select,
  // core code fetch
  input  wire logic              code_req,
  input  wire logic [15:0]       code_addr,
  output logic      [7:0]        code_rdata,
  output logic                   code_ack,
  output logic                   mcycle_phase,
  // core internal data memory
  input  wire logic              imem_req,
  input  wire logic              imem_we,
  input  wire logic [IDAT_AW-1:0] imem_addr,
  input  wire logic [7:0]        imem_wdata,
  output logic      [7:0]        imem_rdata,
  // core external data space decode
  input  wire logic              xspc_req,
  input  wire logic [15:0]       xspc_addr,
  output logic                   epbuf_sel,
  output logic                   mmr_sel,
  output logic      [11:0]       epbuf_addr,
  output logic      [7:0]        mmr_addr,
  // boot rom
  output logic      [ROM_AW-1:0] rom_addr,
  input  wire logic [7:0]        rom_rdata,
  // shared code and fifo ram, ata side
  input  wire logic              ata_req,
  input  wire logic              ata_we,
  input  wire logic [15:0]       ata_addr,
  input  wire logic [7:0]        ata_wdata,
  output logic      [7:0]        ata_rdata,
  output logic                   ata_ack,
  output logic                   ata_err
);

  localparam int unsigned RAM_BYTES = mmd_pkg::CODE_RAM_BYTES + mmd_pkg::FIFO_FIX_BYTES;

  logic [7:0]  ram_mem [RAM_BYTES];
  logic [7:0]  imem_array [mmd_pkg::IMEM_BYTES];
  logic [1:0]  part_reg;
  logic        phase_reg;
  mmd_pkg::mmd_tgt_t tgt_reg;
  logic [15:0] ram_idx_reg;
  logic [7:0]  code_rdata_reg;
  logic        code_ack_reg;
  logic [7:0]  ata_rdata_reg;
  logic        ata_ack_reg;
  logic        ata_err_reg;

  // last code address held by ram under the given partition
  function automatic logic [15:0] code_ram_last(input logic [1:0] p);
    unique case (mmd_pkg::mmd_part_t'(p))
      mmd_pkg::MMD_PART_32K: code_ram_last = mmd_pkg::CFGRAM_LAST_P00;
      mmd_pkg::MMD_PART_16K: code_ram_last = mmd_pkg::CFGRAM_LAST_P01;
      mmd_pkg::MMD_PART_8K:  code_ram_last = mmd_pkg::CFGRAM_LAST_P10;
      default:               code_ram_last = mmd_pkg::CFGRAM_LAST_P10;
    endcase
  endfunction

  function automatic mmd_pkg::mmd_tgt_t code_target(input logic [15:0] a, input logic [1:0] p);
    if (a <= mmd_pkg::ROM_LAST)
      code_target = mmd_pkg::MMD_TGT_ROM;
    else if (a >= mmd_pkg::FIXRAM_BASE && a <= code_ram_last(p))
      code_target = mmd_pkg::MMD_TGT_CRAM;
    else
      code_target = mmd_pkg::MMD_TGT_NONE;
  endfunction

  // partition field; reserved code 11 is refused so the map stays defined
  always_ff @(posedge clk) begin
    if (!rstn)
      part_reg <= mmd_pkg::PART_RESET;
    else if (ram_partition_wr && ram_partition_wdata != mmd_pkg::MMD_PART_RSV)
      part_reg <= ram_partition_wdata;
  end
  assign ram_partition_select = part_reg;

  // two-clock machine cycle: phase 0 decodes, phase 1 returns data
  always_ff @(posedge clk) begin
    if (!rstn)
      phase_reg <= 1'b0;
    else
      phase_reg <= ~phase_reg;
  end
  assign mcycle_phase = phase_reg;

  assign rom_addr = code_addr[ROM_AW-1:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tgt_reg     <= mmd_pkg::MMD_TGT_NONE;
      ram_idx_reg <= 16'h0000;
    end else if (!phase_reg && code_req) begin
      tgt_reg     <= code_target(code_addr, part_reg);
      ram_idx_reg <= code_addr - mmd_pkg::FIXRAM_BASE;
    end
  end

  // one shared ram array: core reads at the low end, ata at the fifo end
  always_ff @(posedge clk) begin
    if (ata_req && ata_we && !ata_err_next())
      ram_mem[ata_index()] <= ata_wdata;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      code_rdata_reg <= 8'h00;
      code_ack_reg   <= 1'b0;
    end else begin
      code_ack_reg <= phase_reg && code_req;
      if (phase_reg && code_req) begin
        unique case (tgt_reg)
          mmd_pkg::MMD_TGT_ROM:  code_rdata_reg <= rom_rdata;
          mmd_pkg::MMD_TGT_CRAM: code_rdata_reg <= ram_mem[ram_idx_reg[15:0] < 16'h8000 ?
                                                     ram_idx_reg[14:0] : 15'h0];
          default:               code_rdata_reg <= 8'h00;
        endcase
      end
    end
  end
  assign code_rdata = code_rdata_reg;
  assign code_ack   = code_ack_reg;

  // ata view: address 0 is the top byte of the fifo region, growing downwards into
  // the configurable ram, so that the fixed 8K is always present
  function automatic logic [15:0] fifo_bytes(input logic [1:0] p);
    fifo_bytes = 16'(RAM_BYTES) - (code_ram_last(p) - mmd_pkg::FIXRAM_BASE + 16'h0001);
  endfunction
  function automatic logic ata_err_next();
    ata_err_next = ata_addr >= fifo_bytes(part_reg);
  endfunction
  function automatic logic [15:0] ata_index();
    ata_index = 16'(RAM_BYTES - 1) - ata_addr;
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ata_rdata_reg <= 8'h00;
      ata_ack_reg   <= 1'b0;
      ata_err_reg   <= 1'b0;
    end else begin
      ata_ack_reg <= ata_req;
      ata_err_reg <= ata_req && ata_err_next();
      ata_rdata_reg <= (ata_req && !ata_err_next()) ? ram_mem[ata_index()] : 8'h00;
    end
  end
  assign ata_rdata = ata_rdata_reg;
  assign ata_ack   = ata_ack_reg;
  assign ata_err   = ata_err_reg;

  // internal data memory
  always_ff @(posedge clk) begin
    if (imem_req && imem_we && imem_addr < IDAT_AW'(mmd_pkg::IMEM_BYTES))
      imem_array[imem_addr - mmd_pkg::IMEM_BASE] <= imem_wdata;
    imem_rdata <= (imem_req && imem_addr < IDAT_AW'(mmd_pkg::IMEM_BYTES)) ?
                  imem_array[imem_addr - mmd_pkg::IMEM_BASE] : 8'h00;
  end

  // external data decode is combinational so the selected target samples it in phase
  always_comb begin
    epbuf_sel = xspc_req && xspc_addr >= mmd_pkg::EPBUF_BASE
                && xspc_addr <= mmd_pkg::EPBUF_LAST;
    mmr_sel   = xspc_req && xspc_addr >= mmd_pkg::MMR_BASE
                && xspc_addr <= mmd_pkg::MMR_LAST;
    epbuf_addr = xspc_addr[11:0];
    mmr_addr   = xspc_addr[7:0];
  end

  // checks
  AST_ACK_TWO: assert property (@(posedge clk) disable iff (!rstn)
    code_ack |-> !$past(code_ack) && $past(phase_reg)) else $error("ack not on machine cycle end");
  AST_PART_RST: assert property (@(posedge clk)
    !rstn |=> part_reg == mmd_pkg::PART_RESET) else $error("partition not reset to 00");
  AST_PART_WR: assert property (@(posedge clk) disable iff (!rstn)
    ram_partition_wr && ram_partition_wdata != 2'h3 |=> part_reg == $past(ram_partition_wdata))
    else $error("partition write lost");
  AST_ROM: assert property (@(posedge clk) disable iff (!rstn)
    !phase_reg && code_req && code_addr <= 16'h1fff |=> tgt_reg == mmd_pkg::MMD_TGT_ROM)
    else $error("rom range not decoded");
  AST_FIX: assert property (@(posedge clk) disable iff (!rstn)
    !phase_reg && code_req && code_addr[15:13] == 3'h1 |=> tgt_reg == mmd_pkg::MMD_TGT_CRAM)
    else $error("fixed code ram not decoded");
  AST_P01: assert property (@(posedge clk) disable iff (!rstn)
    !phase_reg && code_req && part_reg == 2'h1 && code_addr == 16'h6000
    |=> tgt_reg == mmd_pkg::MMD_TGT_NONE) else $error("fifo ram visible to core");
  AST_P10: assert property (@(posedge clk) disable iff (!rstn)
    !phase_reg && code_req && part_reg == 2'h2 && code_addr == 16'h4000
    |=> tgt_reg == mmd_pkg::MMD_TGT_NONE) else $error("fifo ram visible to core");
  AST_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    phase_reg && code_req && tgt_reg == mmd_pkg::MMD_TGT_NONE |=> code_ack && code_rdata == 8'h00)
    else $error("unmapped code read not zero");
  AST_XDEC: assert property (@(posedge clk) disable iff (!rstn)
    xspc_req && xspc_addr == 16'hf0fa |-> !mmr_sel && !epbuf_sel)
    else $error("register window too wide");
  AST_ATA: assert property (@(posedge clk) disable iff (!rstn)
    ata_req && part_reg == 2'h0 && ata_addr == 16'h2000 |=> ata_err)
    else $error("fifo bound wrong");
  COV_FETCH: cover property (@(posedge clk) disable iff (!rstn) code_ack && tgt_reg == mmd_pkg::MMD_TGT_CRAM);
  COV_REPART: cover property (@(posedge clk) disable iff (!rstn) ram_partition_wr ##1 part_reg == 2'h2);
  COV_ATA: cover property (@(posedge clk) disable iff (!rstn) ata_req && ata_we ##1 !ata_err);
  COV_MMR: cover property (@(posedge clk) disable iff (!rstn) mmr_sel);

endmodule
`default_nettype wire

/* verification/mmd_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mmd_core_model (
  // core clock
  input  wire logic        clk,
  // code fetch port
  output logic             code_req,
  output logic [15:0]      code_addr,
  input  wire logic [7:0]  code_rdata,
  input  wire logic        code_ack,
  input  wire logic        mcycle_phase
);
  initial begin
    code_req  = 1'b0;
    code_addr = 16'h0000;
  end
  // a fetch may only open on a phase-0 edge; waiting here keeps us in step
  task automatic fetch(input logic [15:0] a, output logic [7:0] d, output int n);
    @(negedge clk);
    while (mcycle_phase !== 1'b0) @(negedge clk);
    code_req  = 1'b1;
    code_addr = a;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (code_ack !== 1'b1 && n < 8);
    d = code_rdata;
    code_req  = 1'b0;
    // released address must not linger as a valid-looking value
    code_addr = ~a;
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, rstn = 0, ram_partition_wr = 0, code_req, code_ack, mcycle_phase;
  logic imem_req = 0, imem_we = 0, xspc_req = 0, epbuf_sel, mmr_sel;
  logic ata_req = 0, ata_we = 0, ata_ack, ata_err;
  logic [1:0]  ram_partition_wdata = 0, ram_partition_select;
  logic [7:0]  code_rdata, imem_wdata = 0, imem_rdata, mmr_addr, rom_rdata;
  logic [7:0]  ata_wdata = 0, ata_rdata;
  logic [10:0] imem_addr = 0;
  logic [11:0] epbuf_addr;
  logic [12:0] rom_addr;
  logic [15:0] code_addr, xspc_addr = 0, ata_addr = 0;
  logic [15:0] xa[6] = '{16'hdfff, 16'he000, 16'hefff, 16'hf000, 16'hf0f9, 16'hf0fa};
  logic [7:0]  mem[int];
  int          err_total = 0, samples_checked = 0, cyc = 0, cur = 0, n, i, q[$];
  integer      seed = 32'h467dbd2c;
  always #12.5 clk = ~clk;
  // rom content is a pure function of its address
  assign rom_rdata = rom_addr[7:0] ^ {3'h0, rom_addr[12:8]};
  mmd_decoder mmd_decoder_i (.clk, .rstn, .ram_partition_wr, .ram_partition_wdata,
    .ram_partition_select, .code_req, .code_addr, .code_rdata, .code_ack, .mcycle_phase,
    .imem_req, .imem_we, .imem_addr, .imem_wdata, .imem_rdata, .xspc_req,
    .xspc_addr, .epbuf_sel, .mmr_sel, .epbuf_addr, .mmr_addr, .rom_addr, .rom_rdata,
    .ata_req, .ata_we, .ata_addr, .ata_wdata, .ata_rdata, .ata_ack, .ata_err);
  mmd_core_model mmd_core_model_i (.clk, .code_req, .code_addr, .code_rdata, .code_ack,
    .mcycle_phase);
  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic int fsz(int p);
    return p == 0 ? 8192 : p == 1 ? 24576 : 32768;
  endfunction
  task automatic setp(input logic [1:0] p);
    @(negedge clk);
    ram_partition_wr = 1;
    ram_partition_wdata = p;
    @(negedge clk);
    ram_partition_wr = 0;
    if (p != 2'h3) cur = p;
    chk(ram_partition_select, cur[15:0]);
  endtask
  task automatic ata(input logic w, input int a, input logic [7:0] v);
    @(negedge clk);
    ata_req = 1;
    ata_we = w;
    ata_addr = a[15:0];
    ata_wdata = v;
    @(negedge clk);
    ata_req = 0;
    ata_addr = ~ata_addr;
    chk(ata_ack, 1);
    chk(ata_err, a >= fsz(cur));
    if (a >= fsz(cur)) chk(ata_rdata, 0);
    else if (w) mem[a] = v;
    else if (mem.exists(a)) chk(ata_rdata, mem[a]);
  endtask
  task automatic fet(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] g;
    mmd_core_model_i.fetch(a, g, n);
    chk(g, e);
    chk(n[15:0], 2);
    chk(mcycle_phase, 0);
  endtask
  task automatic idt(input logic w, input logic [10:0] a, input logic [7:0] v);
    @(negedge clk);
    imem_req = 1;
    imem_we = w;
    imem_addr = a;
    imem_wdata = v;
    @(negedge clk);
    imem_req = 0;
    imem_we = 0;
    if (!w) chk(imem_rdata, v);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1;
    chk(ram_partition_select, 0);
    fet(16'h0a5c, 8'h56);
    fet(16'h1fff, 8'he0);
    setp(2);
    for (int k = 0; k < 16; k++) begin
      i = 8192 + ($unsigned($random(seed)) % 24576);
      q.push_back(i);
      ata(1, i, 8'($random(seed)));
      ata(0, i, 0);
    end
    ata(1, 32768, 8'h5a);
    ata(0, 32767, 0);
    setp(3);
    fet(16'h4000, 0);
    setp(0);
    foreach (q[k]) fet(16'hbfff - q[k][15:0], mem[q[k]]);
    ata(1, 8192, 8'ha5);
    setp(1);
    fet(16'h6000, 0);
    ata(1, 24576, 8'h3c);
    ata(0, 24575, 0);
    fet(16'ha000, 0);
    // reset again in mid-run: the partition must fall back to its power-up split
    @(negedge clk);
    rstn = 0;
    repeat (2) @(negedge clk);
    rstn = 1;
    cur = 0;
    chk(ram_partition_select, 0);
    chk(code_ack, 0);
    fet(16'ha000, 0);
    idt(1, 11'h47f, 8'h9e);
    idt(0, 11'h47f, 8'h9e);
    idt(0, 11'h480, 8'h00);
    foreach (xa[k]) begin
      @(negedge clk);
      xspc_req = 1;
      xspc_addr = xa[k];
      #1;
      chk(epbuf_sel, xa[k] >= 16'he000 && xa[k] <= 16'hefff);
      chk(mmr_sel, xa[k] >= 16'hf000 && xa[k] <= 16'hf0f9);
      if (epbuf_sel === 1'b1) chk(epbuf_addr, xa[k][11:0]);
      if (mmr_sel === 1'b1) chk(mmr_addr, xa[k][7:0]);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
